/* File: logic/video_link_params.svh */
// Offsets, field positions, reset values and counts of the link status block
// How it works
// - Error pin pulled low while any error flag set
// - Read clears parity/uart; PRBS-off clears PRBS
// - Lock high only when PLL locked and aligned
// - Channel-open pin high exactly while channel enabled
// - Power-down low floats every output, freezes phase sequencing
// - Remote power select sampled after reset release
// - Unused data inputs above width become GPIO
// - Only one side drives link during channel
// - Channel bits sent bi-phase for AC coupling
// - Peripheral interface select UART or I2C
// - Widths 10 to 18 bits, codes 0 to 4
// - Recovered words decoded to parallel outputs
// - Sync bits carried beside data bits
// - Active vsync edge opens control channel
// - Receive line output, transmit line input
// - Sync, data and recovered clock strobe out
// - Channel-open raised at video phase end
// - Idle timer closes channel, activity restarts it
// - Handshake of 546 or 1090 words follows
`ifndef VIDEO_LINK_PARAMS_SVH
`define VIDEO_LINK_PARAMS_SVH
`define REG_CTRL 5'h00
`define REG_TIMEOUT 5'h04
`define REG_STATUS 5'h08
`define REG_ERRORS 5'h0C
`define REG_GPIO_SEL 5'h10
`define CTRL_WIDTH_LSB 0
`define CTRL_VEDGE 4
`define CTRL_PRBS_EN 5
`define CTRL_PERIPH_I2C 6
`define CTRL_HSK_LONG 7
`define CTRL_RESET 8'h04
`define TIMEOUT_RESET 16'h0400
`define WIDTH_MAX_CODE 3'h4
`define HSK_SHORT 11'h222
`define HSK_LONG 11'h442
`define TX_HOLD 5'h10
`endif

/* File: logic/video_link_pkg.sv */
// Types of the link status block
package video_link_pkg;
   typedef enum logic [1:0] {ST_VIDEO, ST_CHAN, ST_HSK} phase_t;
endpackage

/* File: logic/video_link_status.sv */
// Deserializer phase sequencing, status pins and register slave
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "video_link_params.svh"
module video_link_status
   import video_link_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_word_valid,
   input wire logic [19:0] i_word,
   input wire logic i_pll_locked,
   input wire logic i_align_ok,
   input wire logic i_parity_err,
   input wire logic i_prbs_err,
   input wire logic i_uart_err,
   input wire logic i_power_down_n,
   input wire logic i_remote_power_select,
   input wire logic i_cc_tx,
   input wire logic i_link_rx,
   output logic o_cc_rx,
   output logic o_cc_rx_oe,
   output logic o_link_tx,
   output logic o_link_tx_oe,
   output logic o_error_n_o,
   output logic o_error_n_oe,
   output logic o_lock_o,
   output logic o_lock_oe,
   output logic o_ctrl_chan_open,
   output logic o_ctrl_chan_open_oe,
   output logic o_pix_strobe,
   output logic o_hsync,
   output logic o_vsync,
   output logic [15:0] o_dout,
   output logic o_data_valid,
   output logic o_data_oe,
   output logic o_periph_i2c,
   output logic o_remote_power,
   output logic [7:0] o_gpio_sel
);
   // Data bits in use for a width code
   function automatic logic [15:0] data_mask(input logic [2:0] code);
      logic [15:0] m;
      m = 16'h00FF;
      for (int i = 0; i < 4; i++) begin
         if (code > i[2:0]) begin
            m[8 + 2 * i +: 2] = 2'h3;
         end
      end
      return m;
   endfunction

   logic [7:0] ctrl, next_ctrl;
   logic [15:0] timeout, next_timeout;
   logic par_f, prbs_f, uart_f, next_par_f, next_prbs_f, next_uart_f;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic rem_cap, rem_done, next_rem_cap, next_rem_done;
   logic rd_now, wr_now;

   assign rd_now = i_avs_read & ack;
   assign wr_now = i_avs_write & ack;
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
   assign o_avs_readdata = rdata;

   phase_t state, next_state;
   logic [15:0] timer, next_timer;
   logic [10:0] hsk_cnt, next_hsk_cnt;
   logic vs_prev, next_vs_prev;
   logic tx_prev, rx_prev, next_tx_prev, next_rx_prev;
   logic own, next_own;
   logic [4:0] hold, next_hold;
   logic bp, next_bp;
   logic lock, next_lock;
   logic chan, next_chan;
   logic cc_rx, next_cc_rx, ltx, next_ltx, ltx_oe, next_ltx_oe;
   logic strobe, next_strobe, hs, next_hs, vs, next_vs, dv, next_dv;
   logic [15:0] dout, next_dout;
   logic oe, next_oe;
   logic vedge_hit, activity;
   logic [2:0] wcode;
   logic [15:0] used_mask;

   assign wcode = ctrl[`CTRL_WIDTH_LSB +: 3];
   assign used_mask = data_mask(wcode);

   // Register slave and error flags
   always_comb begin
      next_ctrl = ctrl;
      next_timeout = timeout;
      next_ack = (i_avs_read | i_avs_write) & ~ack;
      next_rdata = rdata;
      next_rem_cap = rem_cap;
      next_rem_done = 1'b1;
      if (!rem_done) begin
         next_rem_cap = i_remote_power_select;
      end
      if (wr_now && i_avs_address == `REG_CTRL) begin
         next_ctrl = i_avs_writedata[7:0];
         if (i_avs_writedata[2:0] > `WIDTH_MAX_CODE) begin
            next_ctrl[2:0] = wcode;
         end
      end
      if (wr_now && i_avs_address == `REG_TIMEOUT) begin
         next_timeout = i_avs_writedata[15:0];
      end
      if ((i_avs_read | i_avs_write) && !ack) begin
         unique case (i_avs_address)
            `REG_CTRL: next_rdata = {24'h0, ctrl};
            `REG_TIMEOUT: next_rdata = {16'h0, timeout};
            `REG_STATUS: next_rdata = {27'h0, par_f | prbs_f | uart_f,
               rem_cap, state == ST_HSK, chan, lock};
            `REG_ERRORS: next_rdata = {29'h0, uart_f, prbs_f, par_f};
            `REG_GPIO_SEL: next_rdata = {24'h0, o_gpio_sel};
            default: next_rdata = 32'h0;
         endcase
      end
      next_par_f = par_f;
      next_uart_f = uart_f;
      next_prbs_f = prbs_f;
      if (rd_now && i_avs_address == `REG_ERRORS) begin
         next_par_f = 1'b0;
         next_uart_f = 1'b0;
      end
      if (!next_ctrl[`CTRL_PRBS_EN]) begin
         next_prbs_f = 1'b0;
      end
      if (i_power_down_n) begin
         if (i_parity_err) next_par_f = 1'b1;
         if (i_uart_err) next_uart_f = 1'b1;
         if (i_prbs_err && next_ctrl[`CTRL_PRBS_EN]) next_prbs_f = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl <= `CTRL_RESET;
         timeout <= `TIMEOUT_RESET;
         ack <= 1'b0;
         rdata <= 32'h0;
         rem_cap <= 1'b0;
         rem_done <= 1'b0;
         par_f <= 1'b0;
         prbs_f <= 1'b0;
         uart_f <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         timeout <= next_timeout;
         ack <= next_ack;
         rdata <= next_rdata;
         rem_cap <= next_rem_cap;
         rem_done <= next_rem_done;
         par_f <= next_par_f;
         prbs_f <= next_prbs_f;
         uart_f <= next_uart_f;
      end
   end

   assign o_periph_i2c = ctrl[`CTRL_PERIPH_I2C];
   assign o_remote_power = rem_cap;
   assign o_gpio_sel = ~used_mask[15:8];

   // Vsync is bit 3 of the recovered word, hsync bit 2
   assign vedge_hit = i_word_valid && (ctrl[`CTRL_VEDGE] ?
      (i_word[3] && !vs_prev) : (!i_word[3] && vs_prev));
   assign activity = (i_cc_tx != tx_prev) | (i_link_rx != rx_prev);

   // Phase sequencing and link-facing outputs
   always_comb begin
      next_state = state;
      next_timer = timer;
      next_hsk_cnt = hsk_cnt;
      next_vs_prev = i_word_valid ? i_word[3] : vs_prev;
      next_tx_prev = i_cc_tx;
      next_rx_prev = i_link_rx;
      next_own = own;
      next_hold = hold;
      next_bp = ~bp;
      if (i_power_down_n) begin
         unique case (state)
            ST_VIDEO: begin
               if (vedge_hit) begin
                  next_state = ST_CHAN;
                  next_timer = timeout;
               end
            end
            ST_CHAN: begin
               if (activity) begin
                  next_timer = timeout;
               end else if (timer == 16'h0) begin
                  next_state = ST_HSK;
                  next_hsk_cnt = ctrl[`CTRL_HSK_LONG] ?
                     `HSK_LONG : `HSK_SHORT;
               end else begin
                  next_timer = timer - 16'h1;
               end
            end
            ST_HSK: begin
               if (hsk_cnt != 11'h0) begin
                  if (i_word_valid) next_hsk_cnt = hsk_cnt - 11'h1;
               end else if (i_align_ok && i_pll_locked) begin
                  next_state = ST_VIDEO;
               end
            end
         endcase
      end
      // Half-duplex ownership taken when the control unit starts talking
      if (next_state != ST_CHAN) begin
         next_own = 1'b0;
      end else if (!i_cc_tx) begin
         next_own = 1'b1;
         next_hold = `TX_HOLD;
      end else if (hold != 5'h0) begin
         next_hold = hold - 5'h1;
      end else begin
         next_own = 1'b0;
      end
      next_chan = next_state == ST_CHAN;
      next_lock = i_pll_locked && i_align_ok
         && next_state != ST_HSK;
      next_cc_rx = (next_state == ST_CHAN && !next_own) ? i_link_rx : 1'b1;
      next_ltx = i_cc_tx ^ bp;
      next_ltx_oe = next_own && i_power_down_n;
      next_strobe = i_word_valid;
      next_hs = hs;
      next_vs = vs;
      next_dout = dout;
      next_dv = 1'b0;
      if (i_word_valid && next_state == ST_VIDEO && i_power_down_n) begin
         next_hs = i_word[2];
         next_vs = i_word[3];
         next_dout = i_word[19:4] & data_mask(wcode);
         next_dv = next_lock;
      end
      next_oe = i_power_down_n;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_VIDEO;
         timer <= 16'h0;
         hsk_cnt <= 11'h0;
         vs_prev <= 1'b0;
         tx_prev <= 1'b1;
         rx_prev <= 1'b1;
         own <= 1'b0;
         hold <= 5'h0;
         bp <= 1'b0;
         lock <= 1'b0;
         chan <= 1'b0;
         cc_rx <= 1'b1;
         ltx <= 1'b0;
         ltx_oe <= 1'b0;
         strobe <= 1'b0;
         hs <= 1'b0;
         vs <= 1'b0;
         dout <= 16'h0;
         dv <= 1'b0;
         oe <= 1'b0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         hsk_cnt <= next_hsk_cnt;
         vs_prev <= next_vs_prev;
         tx_prev <= next_tx_prev;
         rx_prev <= next_rx_prev;
         own <= next_own;
         hold <= next_hold;
         bp <= next_bp;
         lock <= next_lock;
         chan <= next_chan;
         cc_rx <= next_cc_rx;
         ltx <= next_ltx;
         ltx_oe <= next_ltx_oe;
         strobe <= next_strobe;
         hs <= next_hs;
         vs <= next_vs;
         dout <= next_dout;
         dv <= next_dv;
         oe <= next_oe;
      end
   end

   // Open-drain pins: error only pulls low, lock only pulls low when unlocked
   assign o_error_n_o = 1'b0;
   assign o_error_n_oe = oe && (par_f | prbs_f | uart_f);
   assign o_lock_o = 1'b0;
   assign o_lock_oe = oe && !lock;
   assign o_ctrl_chan_open = chan;
   assign o_ctrl_chan_open_oe = oe;
   assign o_cc_rx = cc_rx;
   assign o_cc_rx_oe = oe;
   assign o_link_tx = ltx;
   assign o_link_tx_oe = ltx_oe;
   assign o_pix_strobe = strobe;
   assign o_hsync = hs;
   assign o_vsync = vs;
   assign o_dout = dout;
   assign o_data_valid = dv;
   assign o_data_oe = oe;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   err_pin_a: assert property (
      (i_parity_err && i_power_down_n) |=> o_error_n_oe)
      else $error("error pin not asserted");
   err_clear_a: assert property (
      (rd_now && i_avs_address == `REG_ERRORS && !i_parity_err)
      |=> !par_f) else $error("parity flag not cleared");
   prbs_clear_a: assert property (
      !ctrl[`CTRL_PRBS_EN] |-> !prbs_f) else $error("prbs flag stuck");
   lock_pin_a: assert property (
      (!i_pll_locked && i_power_down_n) |=> o_lock_oe)
      else $error("lock not pulled low");
   chan_drop_a: assert property (
      (state == ST_CHAN && next_state == ST_HSK)
      |=> !o_ctrl_chan_open && !o_link_tx_oe) else $error("open pin stuck");
   pd_float_a: assert property (
      !i_power_down_n |=> !o_data_oe && !o_lock_oe && !o_error_n_oe
      && !o_ctrl_chan_open_oe && !o_link_tx_oe) else $error("not floated");
   half_duplex_a: assert property (
      o_link_tx_oe |-> o_cc_rx) else $error("both sides active");
   vsync_open_a: assert property (
      (state == ST_VIDEO && vedge_hit && i_power_down_n)
      |=> state == ST_CHAN ##1 o_ctrl_chan_open)
      else $error("channel did not open");
   timer_close_a: assert property (
      (state == ST_CHAN && timer == 16'h0 && !activity && i_power_down_n)
      |=> state == ST_HSK) else $error("channel did not close");
   hsk_lock_a: assert property (
      (state == ST_HSK && hsk_cnt != 11'h0)
      |=> !o_data_valid && o_lock_oe == oe)
      else $error("lock during handshake");
   width_a: assert property (
      wcode <= `WIDTH_MAX_CODE) else $error("illegal width code");
   bus_wait_a: assert property (
      (i_avs_read && !ack) |=> !o_avs_waitrequest)
      else $error("slave did not answer");

   open_cov: cover property (state == ST_VIDEO ##1 state == ST_CHAN);
   hsk_cov: cover property (state == ST_HSK ##1 state == ST_VIDEO);
   err_cov: cover property (o_error_n_oe ##1 !o_error_n_oe);
endmodule
`default_nettype wire

/* File: tb/serializer_model.sv */
// Far-side serializer model delivering recovered words and link bits
`timescale 1ns/1ps
`default_nettype none
module serializer_model (
   input wire logic clk,
   output logic o_word_valid,
   output logic [19:0] o_word,
   output logic o_link_rx
);
   logic [19:0] last;
   initial begin
      o_word_valid = 1'b0;
      o_word = 20'h00000;
      o_link_rx = 1'b1; // Idle high until the far end replies over the link
      last = 20'h00000;
   end
   // One word: sync bits beside data, encoding bits below
   task automatic send(input logic h, input logic v, input logic [15:0] d);
      @(posedge clk);
      last = {d, v, h, 2'b01};
      o_word <= last;
      o_word_valid <= 1'b1;
      @(posedge clk);
      o_word_valid <= 1'b0;
      o_word <= ~last;
   endtask
   // Handshake words, vsync held at its level after the edge
   task automatic handshake(input int n, input logic v);
      repeat (n) begin
         send(1'b0, v, 16'hA5A5);
      end
   endtask
   // Far end answering over the link while the channel is open
   task automatic reply(input logic b);
      @(posedge clk);
      o_link_rx <= b;
   endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the link status block
`timescale 1ns/1ps
`default_nettype none
`include "video_link_params.svh"
`define CHK(nm, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
   end \
end
module testbench;
   logic i_sys_clk, i_rst_n, i_avs_read, i_avs_write, i_pll_locked;
   logic i_align_ok, i_parity_err, i_prbs_err, i_uart_err, i_power_down_n;
   logic i_remote_power_select, i_cc_tx, i_word_valid, i_link_rx;
   logic [4:0] i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, rd;
   logic [19:0] i_word;
   logic [15:0] o_dout;
   logic [7:0] o_gpio_sel;
   logic o_avs_waitrequest, o_cc_rx, o_cc_rx_oe, o_link_tx, o_link_tx_oe;
   logic o_error_n_o, o_error_n_oe, o_lock_o, o_lock_oe, o_ctrl_chan_open;
   logic o_ctrl_chan_open_oe, o_pix_strobe, o_hsync, o_vsync, o_data_valid;
   logic o_data_oe, o_periph_i2c, o_remote_power;
   int mismatches = 0;
   int checks_done = 0;
   typedef struct packed {
      logic [2:0] code;
      logic [15:0] dout;
      logic [7:0] gpio;
   } row_t;
   row_t rows [5] = '{'{3'h0, 16'h00FF, 8'hFF}, '{3'h1, 16'h03FF, 8'hFC},
      '{3'h2, 16'h0FFF, 8'hF0}, '{3'h3, 16'h3FFF, 8'hC0},
      '{3'h4, 16'hFFFF, 8'h00}};

   video_link_status DUT (.i_sys_clk, .i_rst_n, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
      .i_word_valid, .i_word, .i_pll_locked, .i_align_ok, .i_parity_err,
      .i_prbs_err, .i_uart_err, .i_power_down_n, .i_remote_power_select,
      .i_cc_tx, .i_link_rx, .o_cc_rx, .o_cc_rx_oe, .o_link_tx, .o_link_tx_oe,
      .o_error_n_o, .o_error_n_oe, .o_lock_o, .o_lock_oe, .o_ctrl_chan_open,
      .o_ctrl_chan_open_oe, .o_pix_strobe, .o_hsync, .o_vsync, .o_dout,
      .o_data_valid, .o_data_oe, .o_periph_i2c, .o_remote_power, .o_gpio_sel);
   serializer_model far (.clk(i_sys_clk), .o_word_valid(i_word_valid),
      .o_word(i_word), .o_link_rx(i_link_rx));

   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Avalon transfer held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= ~wr;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      if (o_avs_waitrequest !== 1'b0)
         mismatches++;
      rd = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_sys_clk);
   endtask

   task automatic do_reset(input logic strap);
      @(posedge i_sys_clk);
      i_rst_n <= 1'b0;
      i_remote_power_select <= strap;
      repeat (20) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
   endtask

   task automatic check_regs(input logic strap);
      bus(1'b0, `REG_CTRL, 32'h0);
      `CHK("ctrl", 32'h00000004, rd)
      bus(1'b0, `REG_TIMEOUT, 32'h0);
      `CHK("timeout", 32'h00000400, rd)
      bus(1'b0, `REG_STATUS, 32'h0);
      `CHK("strap", {strap, strap}, {rd[3], o_remote_power})
      bus(1'b0, 5'h14, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("od_level", 2'b00, {o_error_n_o, o_lock_o})
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask

   initial begin
      #200000;
      mismatches++;
      end_sim();
   end

   initial begin
      int n;
      i_rst_n = 1'b0;
      {i_avs_read, i_avs_write, i_parity_err, i_prbs_err, i_uart_err} = 5'h00;
      i_avs_address = 5'h00;
      i_avs_writedata = 32'h0;
      {i_pll_locked, i_align_ok, i_power_down_n, i_cc_tx} = 4'hF;
      i_remote_power_select = 1'b1;
      do_reset(1'b1);
      check_regs(1'b1);
      foreach (rows[i]) begin
         bus(1'b1, `REG_CTRL, {29'h0, rows[i].code});
         far.send(1'b1, 1'b0, 16'hFFFF);
         #1;
         `CHK("dout", rows[i].dout, o_dout)
         `CHK("gpio", rows[i].gpio, o_gpio_sel)
         `CHK("sync", 2'b10, {o_hsync, o_vsync})
         `CHK("strobe", 2'b11, {o_pix_strobe, o_data_valid})
         bus(1'b0, `REG_GPIO_SEL, 32'h0);
         `CHK("gpio_reg", {24'h0, rows[i].gpio}, rd)
      end
      bus(1'b1, `REG_CTRL, 32'h00000007);
      bus(1'b0, `REG_CTRL, 32'h0);
      `CHK("bad_width", 3'h4, rd[2:0])
      // Parity and uart clear on read, prbs only when disabled
      bus(1'b1, `REG_CTRL, 32'h00000024);
      {i_parity_err, i_prbs_err, i_uart_err} <= 3'h7;
      @(posedge i_sys_clk);
      {i_parity_err, i_prbs_err, i_uart_err} <= 3'h0;
      settle(2);
      `CHK("err_pin", 1'b1, o_error_n_oe)
      bus(1'b0, `REG_ERRORS, 32'h0);
      `CHK("err_reg", 32'h00000007, rd)
      settle(2);
      `CHK("prbs_held", 1'b1, o_error_n_oe)
      bus(1'b1, `REG_CTRL, 32'h00000004);
      settle(2);
      `CHK("err_clear", 1'b0, o_error_n_oe)
      for (int k = 0; k < 2; k++) begin
         @(posedge i_sys_clk);
         i_pll_locked <= k[0];
         i_align_ok <= ~k[0];
         settle(3);
         `CHK("unlock", 1'b1, o_lock_oe)
         @(posedge i_sys_clk);
         i_pll_locked <= 1'b1;
         i_align_ok <= 1'b1;
         settle(3);
         `CHK("lock", 1'b0, o_lock_oe)
      end
      bus(1'b1, `REG_TIMEOUT, 32'h00000008);
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, `REG_CTRL, m ? 32'h000000D4 : 32'h00000004);
         `CHK("periph", m[0], o_periph_i2c)
         far.send(1'b0, ~m[0], 16'h0000);
         #1;
         far.send(1'b0, m[0], 16'h0000);
         settle(3);
         `CHK("open", 1'b1, o_ctrl_chan_open)
         far.reply(1'b0);
         settle(2);
         `CHK("fwd", 1'b0, o_cc_rx)
         @(posedge i_sys_clk);
         i_cc_tx <= 1'b0;
         settle(2);
         `CHK("own", 2'b11, {o_link_tx_oe, o_cc_rx})
         rd[0] = o_link_tx;
         settle(1);
         `CHK("biphase", ~rd[0], o_link_tx)
         far.reply(1'b1);
         i_cc_tx <= 1'b1;
         settle(6);
         `CHK("restart", 1'b1, o_ctrl_chan_open)
         n = 0;
         while (o_ctrl_chan_open !== 1'b0 && n < 40) begin
            settle(1);
            n++;
         end
         `CHK("close", 2'b01, {o_ctrl_chan_open, o_lock_oe})
         far.handshake(m ? 1089 : 545, m[0]);
         settle(3);
         `CHK("hsk", 2'b10, {o_lock_oe, o_data_valid})
         far.handshake(1, m[0]);
         settle(4);
         `CHK("relock", 1'b0, o_lock_oe)
         far.send(1'b0, m[0], 16'h1234);
         #1;
         `CHK("video", 17'h11234, {o_data_valid, o_dout})
      end
      @(posedge i_sys_clk);
      i_power_down_n <= 1'b0;
      settle(2);
      `CHK("pd", 6'h00, {o_cc_rx_oe, o_link_tx_oe, o_error_n_oe, o_lock_oe,
         o_ctrl_chan_open_oe, o_data_oe})
      @(posedge i_sys_clk);
      i_power_down_n <= 1'b1;
      settle(2);
      `CHK("pu", 3'h7, {o_cc_rx_oe, o_ctrl_chan_open_oe, o_data_oe})
      do_reset(1'b0);
      check_regs(1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
